// ===== design/srs_pkg.sv
// Purpose: Constants and types shared by the system reset sequencer
// Assumes: 50 MHz system clock, 8-bit register port
// Notes:   Times are in ns; cycle counts derive from them
package srs_pkg;

  // ****************************************
  // Clock and time-outs
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_TIMEOUT_NS = 20000;
  localparam int POR_IND_NS = 40000;
  localparam int BO_IND_NS = 30000;
  localparam int WDT_IND_NS = 10000;
  localparam int RST_TIMEOUT_CYC = (RST_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_IND_CYC = (POR_IND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BO_IND_CYC = (BO_IND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_IND_CYC = (WDT_IND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_HOLD_CYC = 4;
  localparam int CNT_W = 16;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CAUSE_W = 6;
  localparam logic [3:0] OFF_CAUSE = 4'h0;
  localparam logic [3:0] OFF_MASK = 4'h1;
  localparam logic [3:0] OFF_CTRL = 4'h2;
  localparam logic [3:0] OFF_OSC = 4'h3;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BO = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_DBG = 4;
  localparam int CAUSE_STOP = 5;
  localparam int CTRL_DBGREQ = 0;
  localparam int CTRL_PININD = 1;
  localparam int OSC_SEL_LO = 0;
  localparam int OSC_INTOSC_EN = 2;
  localparam logic [1:0] CLKSEL_INTOSC = 2'h0;
  localparam logic [5:0] CAUSE_RST = 6'h00;
  localparam logic [5:0] MASK_RST = 6'h00;

  typedef enum logic [1:0] {
    SRS_IDLE = 2'b00,
    SRS_ACTIVE = 2'b01,
    SRS_STOPHOLD = 2'b10
  } srs_state_t;

endpackage

// ===== design/srs_top.sv
// Purpose: System reset sequencer with cause flags and reset pin indicator
// Assumes: Reset pin arrives asynchronously; other inputs are on mclk
// Notes:   Own registers sit on a plain 8-bit port, read data one cycle late
// Notes on behaviour
// RULE1 Pin low four clocks always resets; code ignores the pin while its own drive, delayed two clocks, is on
// RULE2 Stay in reset while pin held low
// RULE3 Leave reset first edge after pin release
// RULE4 External pin reset sets external cause flag
// RULE5 Pin drives open-drain low during system reset; code releases it when its counts end, clocks before reset is left
// RULE6 Internal event drives pin for source delay
// RULE7 Debug request bit starts system reset
// RULE8 Debug request bit clears during that reset
// RULE9 Debug reset sets watchdog power-on flag
// RULE10 Stop recovery holds CPU four oscillator cycles
// RULE11 Stop recovery touches only cause, oscillator
// RULE12 Stop recovery enables and selects internal oscillator
// RULE13 Time-out and indicator delays are parameters
`timescale 1ns/1ps
module srs_top import srs_pkg::*; #(
  parameter int RST_TIMEOUT = RST_TIMEOUT_CYC,
  parameter int POR_IND = POR_IND_CYC,
  parameter int BO_IND = BO_IND_CYC,
  parameter int WDT_IND = WDT_IND_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  input wire logic porEvent,
  input wire logic brownoutDetect,
  input wire logic watchdogEvent,
  input wire logic stopEnter,
  input wire logic wakeEvent,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [DATA_W-1:0] regRdData,
  output logic sysResetOut,
  output logic cpuResetOut,
  output logic debugUnitReset,
  output logic wdtPorFlagSet,
  output logic intOscEnable,
  output logic [1:0] clkSelect,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    srs_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] indCnt;
    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] mask;
    logic dbgReq;
    logic dbgInit;
    logic pinIndEn;
    logic intOscEn;
    logic [1:0] clkSel;
    logic inStop;
    logic sync0;
    logic sync1;
    logic oeD1;
    logic oeD2;
    logic wdtPor;
    logic [DATA_W-1:0] rdData;
  } srs_regs_t;

  srs_regs_t s_r;
  srs_regs_t s_nxt;
  logic pinLow;
  logic extLow;
  logic intEvt;
  logic drvOe;
  logic startRst;
  logic quiet;
  logic wakeStart;

  // Pin level seen after two flops; own drive masked out
  assign pinLow = ~s_r.sync1; // RULE1
  assign extLow = pinLow & ~s_r.oeD2;
  assign intEvt = porEvent | brownoutDetect | watchdogEvent;
  assign startRst = intEvt | extLow | s_r.dbgReq;
  assign quiet = ~drvOe & ~s_r.oeD1 & ~s_r.oeD2;
  assign wakeStart = (s_r.st == SRS_IDLE) & ~startRst & s_r.inStop & wakeEvent;

  // Pin driven low while counting, while indicating, or when enabled
  assign drvOe = ((s_r.st == SRS_ACTIVE) && (s_r.cnt != '0)) || (s_r.indCnt != '0) || s_r.pinIndEn; // RULE5 RULE6
  assign resetPinOe = drvOe;
  assign resetPinOut = 1'b0;

  // Outputs decoded from state flops
  assign sysResetOut = (s_r.st == SRS_ACTIVE);
  assign cpuResetOut = (s_r.st != SRS_IDLE); // RULE10
  assign debugUnitReset = (s_r.st == SRS_ACTIVE) & ~s_r.dbgInit; // RULE7
  assign wdtPorFlagSet = s_r.wdtPor;
  assign intOscEnable = s_r.intOscEn;
  assign clkSelect = s_r.clkSel;
  assign regRdData = s_r.rdData;
  assign irq = |(s_r.cause & s_r.mask);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync0 = resetPinIn;
    s_nxt.sync1 = s_r.sync0;
    s_nxt.oeD1 = drvOe;
    s_nxt.oeD2 = s_r.oeD1;
    s_nxt.rdData = '0;
    s_nxt.wdtPor = 1'b0;
    // Register reads
    if (regRdEn) begin
      if (regAddr == OFF_CAUSE) begin
        s_nxt.rdData = DATA_W'(s_r.cause);
      end else if (regAddr == OFF_MASK) begin
        s_nxt.rdData = DATA_W'(s_r.mask);
      end else if (regAddr == OFF_CTRL) begin
        s_nxt.rdData = DATA_W'({s_r.pinIndEn, s_r.dbgReq});
      end else if (regAddr == OFF_OSC) begin
        s_nxt.rdData = DATA_W'({s_r.intOscEn, s_r.clkSel});
      end else if (regAddr == OFF_STAT) begin
        s_nxt.rdData = DATA_W'({s_r.inStop, pinLow, s_r.st});
      end
    end
    // Register writes; cause bits clear on writing one
    if (regWrEn) begin
      if (regAddr == OFF_CAUSE) begin
        s_nxt.cause = s_r.cause & ~regWrData[CAUSE_W-1:0];
      end else if (regAddr == OFF_MASK) begin
        s_nxt.mask = regWrData[CAUSE_W-1:0];
      end else if (regAddr == OFF_CTRL) begin
        s_nxt.dbgReq = regWrData[CTRL_DBGREQ];
        s_nxt.pinIndEn = regWrData[CTRL_PININD];
      end else if (regAddr == OFF_OSC) begin
        s_nxt.intOscEn = regWrData[OSC_INTOSC_EN];
        s_nxt.clkSel = regWrData[OSC_SEL_LO +: 2];
      end
    end
    // Indicator delay; a new event reloads it, power-on over brown-out over watchdog
    if (s_r.indCnt != '0) begin
      s_nxt.indCnt = s_r.indCnt - CNT_W'(1);
    end
    if (porEvent) begin
      s_nxt.indCnt = CNT_W'(POR_IND); // RULE6 RULE13
    end else if (brownoutDetect) begin
      s_nxt.indCnt = CNT_W'(BO_IND);
    end else if (watchdogEvent) begin
      s_nxt.indCnt = CNT_W'(WDT_IND);
    end
    // Events set cause bits after any clear so setting wins
    if (extLow) begin
      s_nxt.cause[CAUSE_EXT] = 1'b1; // RULE4
    end
    if (porEvent) begin
      s_nxt.cause[CAUSE_POR] = 1'b1;
    end
    if (brownoutDetect) begin
      s_nxt.cause[CAUSE_BO] = 1'b1;
    end
    if (watchdogEvent) begin
      s_nxt.cause[CAUSE_WDT] = 1'b1;
    end
    // Sequencer
    case (s_r.st)
      SRS_ACTIVE: begin
        // Counter starts at the full time-out so the pin is held that many cycles
        if (intEvt) begin
          s_nxt.cnt = CNT_W'(RST_TIMEOUT); // RULE13
        end else if (s_r.cnt != '0) begin
          s_nxt.cnt = s_r.cnt - CNT_W'(1);
        end else if (quiet && !pinLow) begin
          s_nxt.st = SRS_IDLE; // RULE2 RULE3
          s_nxt.wdtPor = s_r.dbgInit; // RULE9
          s_nxt.dbgInit = 1'b0;
        end
      end
      SRS_STOPHOLD: begin
        if (s_r.cnt != '0) begin
          s_nxt.cnt = s_r.cnt - CNT_W'(1); // RULE10
        end else begin
          s_nxt.st = SRS_IDLE;
        end
      end
      default: begin
        if (stopEnter) begin
          s_nxt.inStop = 1'b1;
        end
      end
    endcase
    // Stop recovery changes only cause and oscillator state
    if (wakeStart) begin
      s_nxt.st = SRS_STOPHOLD; // RULE11
      s_nxt.cnt = CNT_W'(STOP_HOLD_CYC - 1);
      s_nxt.inStop = 1'b0;
      s_nxt.cause[CAUSE_STOP] = 1'b1;
      s_nxt.intOscEn = 1'b1; // RULE12
      s_nxt.clkSel = CLKSEL_INTOSC;
    end
    // Any reset source starts the system reset from idle or stop hold
    if (startRst && (s_r.st != SRS_ACTIVE)) begin
      s_nxt.st = SRS_ACTIVE; // RULE2 RULE7
      s_nxt.cnt = CNT_W'(RST_TIMEOUT);
      // Debug unit is spared only when the debug request alone started it
      s_nxt.dbgInit = s_r.dbgReq & ~intEvt & ~extLow;
      s_nxt.dbgReq = 1'b0; // RULE8
      s_nxt.pinIndEn = 1'b0;
      s_nxt.inStop = 1'b0;
      s_nxt.intOscEn = 1'b1;
      s_nxt.clkSel = CLKSEL_INTOSC;
      if (s_r.dbgReq) begin
        s_nxt.cause[CAUSE_DBG] = 1'b1;
      end
    end
    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.st = SRS_IDLE;
      s_nxt.sync0 = 1'b1;
      s_nxt.sync1 = 1'b1;
      s_nxt.cause = CAUSE_RST;
      s_nxt.mask = MASK_RST;
      s_nxt.intOscEn = 1'b1;
      s_nxt.clkSel = CLKSEL_INTOSC;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  // ****************************************
  // Checks
  // ****************************************
  // No reset source may interrupt the stop hold while it is being checked
  sequence stopQuiet;
    (!intEvt && !extLow && !s_r.dbgReq) [*5];
  endsequence

  a_pin_holds_reset: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    extLow |=> sysResetOut)
    else $error("Pin low did not hold system reset");

  a_pin_filter_len: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    (!s_r.oeD1 && !s_r.oeD2 && !drvOe && !resetPinIn) [*4] |-> ##[0:1] sysResetOut)
    else $error("Four-cycle pin pulse missed");

  a_release_exit: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    (sysResetOut && s_r.cnt == '0 && !intEvt && quiet && !pinLow) |=> (s_r.st == SRS_IDLE))
    else $error("Reset not left after pin release");

  a_ext_flag_set: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
    ($rose(sysResetOut) && $past(extLow)) |-> s_r.cause[CAUSE_EXT])
    else $error("External cause flag not set");

  a_pin_indicates: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    (sysResetOut && s_r.cnt != '0) |-> (resetPinOe && !resetPinOut))
    else $error("Pin not driven low in reset");

  a_por_pin_low: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    porEvent |=> resetPinOe [*8])
    else $error("Pin not held after power-on event");

  a_dbg_starts: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7 RULE8
    (s_r.dbgReq && s_r.st != SRS_ACTIVE) |=>
      (sysResetOut && !s_r.dbgReq && (debugUnitReset == ($past(intEvt) || $past(extLow)))))
    else $error("Debug request did not start reset");

  a_dbg_por_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    (sysResetOut && s_r.dbgInit && s_nxt.st == SRS_IDLE) |=> wdtPorFlagSet)
    else $error("Watchdog power-on flag not set");

  // Stop recovery: CPU held four cycles, released when nothing interrupts
  a_stop_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    (wakeStart ##1 stopQuiet) |-> !cpuResetOut)
    else $error("Stop recovery hold wrong");

  a_stop_cpu_held: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    wakeStart |=> cpuResetOut [*4])
    else $error("CPU not held four cycles");

  a_stop_keeps_regs: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    wakeStart |=> ($stable(s_r.mask) && $stable(s_r.pinIndEn)))
    else $error("Stop recovery changed other state");

  a_stop_osc_sel: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    wakeStart |=> (intOscEnable && clkSelect == CLKSEL_INTOSC && s_r.cause[CAUSE_STOP]))
    else $error("Stop recovery did not select oscillator");

  a_rst_osc_sel: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    $rose(sysResetOut) |-> (intOscEnable && clkSelect == CLKSEL_INTOSC))
    else $error("System reset did not select oscillator");

  a_bo_pin_low: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    brownoutDetect |=> resetPinOe [*8])
    else $error("Pin not held after brown-out event");

  a_wdt_pin_low: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    watchdogEvent |=> resetPinOe [*8])
    else $error("Pin not held after watchdog event");

endmodule

// ===== testbench/srs_board_model.sv
// Purpose: Board side of the reset pin: pull-up plus a reset switch
// Assumes: Pin is open drain with a pull-up to high
// Notes: Other board parts take the pin level as their reset
`timescale 1ns/1ps
module srs_board_model (
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic switchLow,
  output logic resetPinIn
);
  // ****
  // Wired pin level
  // ****
  // Switch held for a chosen length; pull-up wins once all drivers let go
  assign resetPinIn = !(switchLow || (resetPinOe && !resetPinOut));
endmodule

// ===== testbench/srs_top_tb_top.sv
// Purpose: Self-checking bench for the system reset sequencer
// Assumes: Short time-outs set through parameters
// Notes: Cause and mask are mirrored in integers for expectations
`timescale 1ns/1ps
module srs_top_tb_top import srs_pkg::*;;
  // ****
  // Signals and mirror
  // ****
  localparam int TO = 10;
  localparam int IND [3] = '{12, 10, 8};
  logic mclk = 0, rst_n = 0, switchLow = 0, regWrEn = 0, regRdEn = 0;
  logic [4:0] evt = '0;
  logic [3:0] regAddr = '0;
  logic [7:0] regWrData = '0, regRdData;
  logic resetPinIn, resetPinOut, resetPinOe, sysResetOut, cpuResetOut;
  logic debugUnitReset, wdtPorFlagSet, intOscEnable, irq;
  logic [1:0] clkSelect;
  logic [31:0] lfsrR = 32'h1d02;
  int error_cnt = 0, tests_run = 0, causeM = 0, maskM = 0, n, m, porCnt = 0, cyc = 0;

  srs_top #(.RST_TIMEOUT(TO), .POR_IND(IND[0]), .BO_IND(IND[1]), .WDT_IND(IND[2])) dut (
    .mclk(mclk), .rst_n(rst_n), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .porEvent(evt[0]), .brownoutDetect(evt[1]), .watchdogEvent(evt[2]),
    .stopEnter(evt[3]), .wakeEvent(evt[4]), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .sysResetOut(sysResetOut),
    .cpuResetOut(cpuResetOut), .debugUnitReset(debugUnitReset), .wdtPorFlagSet(wdtPorFlagSet),
    .intOscEnable(intOscEnable), .clkSelect(clkSelect), .irq(irq));
  srs_board_model board (.resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .switchLow(switchLow), .resetPinIn(resetPinIn));

  // Clock
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Hang guard and flag pulse counter
  always @(posedge mclk) begin
    cyc++;
    if (wdtPorFlagSet === 1'b1) porCnt++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ****
  // Tasks
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
    #1;
  endtask
  // Read then check data and interrupt level against the mirror
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp);
    chk(irq, (causeM & maskM) != 0);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    evt[i] <= 1'b1;
    @(posedge mclk);
    evt[i] <= 1'b0;
    #1;
  endtask
  // Wait out a system reset, counting pin drive cycles
  task automatic wait_idle;
    n = 0;
    m = 0;
    while (sysResetOut === 1'b1 && n < 300) begin
      if (resetPinOe === 1'b1) m++;
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(OFF_CAUSE, 8'h00);
    rdc(OFF_MASK, 8'h00);
    rdc(OFF_OSC, 8'h04);
    rdc(4'hf, 8'h00);
    $display("reset values done");
    // Shortest sure pin pulse, then a hold past the time-out
    @(posedge mclk) switchLow <= 1'b1;
    repeat (4) @(posedge mclk);
    switchLow <= 1'b0;
    #1;
    chk(sysResetOut, 1);
    chk(resetPinOe, 1);
    chk(resetPinOut, 0);
    chk(debugUnitReset, 1);
    wait_idle();
    causeM = 1;
    rdc(OFF_CAUSE, 8'h01);
    @(posedge mclk) switchLow <= 1'b1;
    repeat (TO + 20) @(posedge mclk);
    #1;
    chk(sysResetOut, 1);
    @(posedge mclk) switchLow <= 1'b0;
    #1;
    wait_idle();
    chk(n <= 4, 1);
    $display("pin reset done");
    // Internal sources drive the pin for their own delay or the time-out, whichever is longer
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      wait_idle();
      chk(8'(m), 8'((IND[i] > TO) ? IND[i] : TO));
      causeM |= 1 << (i + 1);
    end
    rdc(OFF_CAUSE, 8'(causeM));
    wr(OFF_CTRL, 8'h02);
    chk(resetPinOe, 1);
    wr(OFF_CTRL, 8'h00);
    $display("internal reset done");
    // Debug-started reset
    chk(8'(porCnt), 8'h00);
    wr(OFF_CTRL, 8'h01);
    @(posedge mclk);
    #1;
    chk(sysResetOut, 1);
    chk(debugUnitReset, 0);
    rdc(OFF_CTRL, 8'h00);
    wait_idle();
    repeat (2) @(posedge mclk);
    chk(8'(porCnt), 8'h01);
    causeM |= 16;
    $display("debug reset done");
    // Stop recovery with a random mask held across it
    lfsrR = lfsr(lfsrR);
    maskM = int'(lfsrR[5:0]) | 1;
    wr(OFF_MASK, 8'(maskM));
    wr(OFF_OSC, 8'h01);
    pulse(3);
    pulse(4);
    chk({intOscEnable, clkSelect}, 8'h04);
    n = 0;
    repeat (6) begin
      if (cpuResetOut === 1'b1) n++;
      chk(sysResetOut, 0);
      @(posedge mclk);
      #1;
    end
    chk(8'(n), 8'h04);
    causeM |= 32;
    rdc(OFF_OSC, 8'h04);
    rdc(OFF_MASK, 8'(maskM));
    rdc(OFF_CAUSE, 8'(causeM));
    $display("stop recovery done");
    // Interrupt mask and clear
    maskM = 0;
    wr(OFF_MASK, 8'h00);
    rdc(OFF_CAUSE, 8'(causeM));
    maskM = 63;
    wr(OFF_MASK, 8'h3f);
    wr(OFF_CAUSE, 8'h3f);
    causeM = 0;
    rdc(OFF_CAUSE, 8'h00);
    $display("interrupt done");
    report_and_stop();
  end
endmodule
